// [hdl/sbr_bank_read.sv]
// Bank state tracking, command acceptance and read burst output of a DDR DRAM device.
// Assumes command pins are synchronous to link_clk_i and a controller that keeps its own timing.
// What this block does and relies on
// R1: Controller relies on command rules only with clock enable high on two edges.
// R2: Chip select high registers no command; running operations continue.
// R3: No-operation registers nothing and disturbs nothing in progress.
// R4: Controller never issues commands in states or sequences not allowed.
// R5: Bank idle after precharge time, active after activate time, reading until burst ends.
// R6: Auto precharge starts at earliest legal precharge for reads, after recovery for writes.
// R7: During auto-precharge access period only activate and precharge go to other banks.
// R8: Refresh and mode load only issued with all banks idle.
// R9: Burst terminate acts only on the bank holding the current read.
// R10: Write after read only once data ends, else terminate the read first.
// R11: Mode word loads only with all banks idle; then commands wait the load delay.
// R12: Activate opens the addressed row in the selected bank; many banks may be open.
// R13: Controller waits activate time before reading or writing a new row.
// R14: Controller spaces same-bank activates and closes the row before another.
// R15: Controller spaces activates to different banks by the bank-to-bank time.
// R16: An open row stays open until precharge or an auto-precharge access.
// R17: Read bursts from the open row; auto precharge bit closes the row afterwards.
// R18: Strobe has low preamble, rises with first data, low with last element.
// R19: After the last burst the data pins are released.
// R20: A new read concatenates or truncates the earlier burst; data follows on.
// R21: A read is accepted on any cycle after an earlier read.
// R22: Burst terminate cuts read data after the column latency.
// R23: Precharge may truncate a read; the bank then waits the precharge time.
// R24: Burst terminate truncates the most recent read and never a write.
// R25: Precharge with the auto precharge bit set closes all banks, else one.
// R26: Each bank tracked on its own; commands sampled on the clock rising edge.
`timescale 1ns/10ps
module sbr_bank_read
  import sbr_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic              link_clk_i,
  input  wire logic              cke_i,
  input  wire logic              cs_n_i,
  input  wire logic              ras_n_i,
  input  wire logic              cas_n_i,
  input  wire logic              we_n_i,
  input  wire logic [BA_W-1:0]   ba_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  output logic      [DQ_W-1:0]   dq_rise_o,
  output logic      [DQ_W-1:0]   dq_fall_o,
  output logic                   dq_oe_o,
  output logic                   dqs_o,
  output logic                   dqs_oe_o,
  output logic                   all_banks_idle_o,
  output logic                   read_busy_o,
  output logic                   read_done_o
);

  // Link-side reset and state
  logic                  lrst_meta_q;
  logic                  lrst_q;
  logic                  cke_prev_q;
  logic [MODE_W-1:0]     mode_q;
  logic [3:0]            mrd_q;
  sbr_bank_state_t       bank_state_q [BANKS];
  logic [3:0]            bank_tmr_q   [BANKS];
  logic [ADDR_W-1:0]     bank_row_q   [BANKS];
  logic [BANKS-1:0]      bank_open;
  logic [BANKS-1:0]      bank_idle;
  logic [BA_W-1:0]       last_rd_bank_q;
  logic                  rp_v_q    [PIPE_D];
  logic                  rp_stop_q [PIPE_D];
  logic [BA_W-1:0]       rp_bank_q [PIPE_D];
  logic [COL_W-1:0]      rp_col_q  [PIPE_D];
  logic [3:0]            brst_cnt_q;
  logic [COL_W-1:0]      brst_col_q;
  logic [BA_W-1:0]       brst_bank_q;
  logic [ADDR_W-1:0]     brst_row_q;
  logic                  all_idle_q;
  logic                  done_tgl_q;
  // Ref-side crossing flops
  logic [2:0]            idle_sync_q;
  logic [2:0]            busy_sync_q;
  logic [2:0]            done_sync_q;

  // Decoded command and derived mode values
  logic                  cmd_ok;
  logic [2:0]            cmd;
  logic                  is_act;
  logic                  is_rd;
  logic                  is_wr;
  logic                  is_pre;
  logic                  is_bst;
  logic                  is_mode;
  logic                  pre_all;
  logic                  rd_go;
  logic                  bst_go;
  logic                  pre_trunc;
  logic                  push;
  logic [3:0]            pairs;
  logic [1:0]            cl_cyc;
  logic                  brst_start;
  logic                  brst_last;

  // Element pattern from bank, row and column
  function automatic logic [DQ_W-1:0] elem(input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] r,
                                           input logic [COL_W-1:0] c);
    elem = {b, r[5:0], c[7:0]};
  endfunction

  // Reset into the link domain through two flops
  always_ff @(posedge link_clk_i)
  begin
    lrst_meta_q <= rst_i;
    lrst_q      <= lrst_meta_q;
  end

  // Mode word decode
  always_comb
  begin
    case (mode_q[MODE_BL_LSB +: 3])
      BL_CODE_2: pairs = 4'h1;
      BL_CODE_4: pairs = 4'h2;
      BL_CODE_8: pairs = 4'h4;
      default:   pairs = 4'h2;
    endcase
    cl_cyc = (mode_q[MODE_CL_LSB +: 3] == CL_CODE_2) ? 2'h2 : 2'h3;  // R18
  end

  // Command decode on the rising edge; deselect and no-op register nothing
  assign cmd       = {ras_n_i, cas_n_i, we_n_i};
  assign cmd_ok    = cke_prev_q & cke_i & ~cs_n_i & (mrd_q == 4'h0);  // R2 R3 R11 R26
  assign is_act    = cmd_ok & (cmd == CMD_ACT);
  assign is_rd     = cmd_ok & (cmd == CMD_READ);
  assign is_wr     = cmd_ok & (cmd == CMD_WRITE);
  assign is_pre    = cmd_ok & (cmd == CMD_PRE);
  assign is_bst    = cmd_ok & (cmd == CMD_BST);
  assign is_mode   = cmd_ok & (cmd == CMD_MODE) & all_idle_q & ~dq_oe_o & ~dqs_oe_o;  // R11
  assign pre_all   = addr_i[AUTO_PRECHARGE_SELECT_BIT];  // R25
  assign rd_go     = is_rd & bank_open[ba_i];  // R17 R21
  assign bst_go    = is_bst & (bank_state_q[last_rd_bank_q] == BK_READ);  // R9 R24
  assign pre_trunc = is_pre & (pre_all | (ba_i == last_rd_bank_q))
                     & (bank_state_q[last_rd_bank_q] == BK_READ);  // R23
  assign push      = rd_go | bst_go | pre_trunc;
  assign bank_idle = {bank_state_q[3] == BK_IDLE, bank_state_q[2] == BK_IDLE,
                      bank_state_q[1] == BK_IDLE, bank_state_q[0] == BK_IDLE};

  // Clock enable history, mode word and load delay
  always_ff @(posedge link_clk_i)
  begin
    if (lrst_q)
    begin
      cke_prev_q     <= 1'b0;
      mode_q         <= MODE_RESET;
      mrd_q          <= 4'h0;
      last_rd_bank_q <= '0;
      all_idle_q     <= 1'b1;
    end
    else
    begin
      cke_prev_q <= cke_i;
      all_idle_q <= &bank_idle;
      if (is_mode)
      begin
        mode_q <= addr_i[MODE_W-1:0];  // R11
        mrd_q  <= MODE_LOAD_CYC;
      end
      else if (mrd_q != 4'h0)
        mrd_q <= mrd_q - 4'h1;
      if (rd_go)
        last_rd_bank_q <= ba_i;  // R24
    end
  end

  // One state machine per bank
  for (genvar b = 0; b < BANKS; b++)
  begin : g_bank
    logic sel;
    assign sel          = (ba_i == BA_W'(b));
    assign bank_open[b] = (bank_state_q[b] == BK_ACTIVE) | (bank_state_q[b] == BK_READ)
                          | (bank_state_q[b] == BK_WRITE);

    always_ff @(posedge link_clk_i)
    begin
      if (lrst_q)
      begin
        bank_state_q[b] <= BK_IDLE;
        bank_tmr_q[b]   <= 4'h0;
        bank_row_q[b]   <= '0;
      end
      else
      begin
        if (bank_tmr_q[b] != 4'h0)
          bank_tmr_q[b] <= bank_tmr_q[b] - 4'h1;
        case (bank_state_q[b])
          BK_IDLE:
            if (is_act & sel)
            begin
              bank_state_q[b] <= BK_ACTIVATING;  // R12
              bank_row_q[b]   <= addr_i;
              bank_tmr_q[b]   <= ACTIVATE_CYC - 4'h1;
            end
          BK_ACTIVATING:
            // Leave on the last timer cycle so a read at the activate time is taken
            if (bank_tmr_q[b] <= 4'h1)
              bank_state_q[b] <= BK_ACTIVE;  // R5
          BK_ACTIVE, BK_READ, BK_WRITE:
            if (is_pre & (pre_all | sel))
            begin
              bank_state_q[b] <= BK_PRECHARGING;  // R16 R23 R25
              bank_tmr_q[b]   <= PRECHARGE_CYC - 4'h1;
            end
            else if (is_rd & sel)
            begin
              bank_state_q[b] <= addr_i[AUTO_PRECHARGE_SELECT_BIT] ? BK_RD_AUTO : BK_READ;  // R17
              bank_tmr_q[b]   <= addr_i[AUTO_PRECHARGE_SELECT_BIT] ? pairs - 4'h1
                                 : {2'h0, cl_cyc} + pairs - 4'h1;  // R6
            end
            else if (is_wr & sel)
            begin
              bank_state_q[b] <= addr_i[AUTO_PRECHARGE_SELECT_BIT] ? BK_WR_AUTO : BK_WRITE;
              bank_tmr_q[b]   <= addr_i[AUTO_PRECHARGE_SELECT_BIT] ? pairs + WR_RECOV_CYC : pairs;  // R6
            end
            else if (bst_go & (last_rd_bank_q == BA_W'(b)))
              bank_tmr_q[b] <= {2'h0, cl_cyc} - 4'h1;  // R9 R22
            else if ((bank_state_q[b] != BK_ACTIVE) & (bank_tmr_q[b] == 4'h0))
              bank_state_q[b] <= BK_ACTIVE;  // R5
          BK_RD_AUTO, BK_WR_AUTO:
            if (bank_tmr_q[b] == 4'h0)
            begin
              bank_state_q[b] <= BK_PRECHARGING;  // R6
              bank_tmr_q[b]   <= PRECHARGE_CYC - 4'h1;
            end
          BK_PRECHARGING:
            // Idle in time for an activate exactly at the precharge time
            if (bank_tmr_q[b] <= 4'h1)
              bank_state_q[b] <= BK_IDLE;  // R5
          default:
            bank_state_q[b] <= BK_IDLE;
        endcase
      end
    end

    // Activate opens the addressed bank
    property p_act_opens;  // R12
      @(posedge link_clk_i) disable iff (lrst_q)
      (is_act && sel && bank_state_q[b] == BK_IDLE) |=> (bank_state_q[b] == BK_ACTIVATING)
        ##(ACTIVATE_CYC - 4'h1) (bank_state_q[b] == BK_ACTIVE);
    endproperty
    a_act_opens: assert property (p_act_opens) else $error("activate did not open bank on time");  // R12

    // Open row stays open without a closing command
    property p_row_stays;
      @(posedge link_clk_i) disable iff (lrst_q)
      (bank_state_q[b] == BK_ACTIVE && !is_pre && !is_rd && !is_wr) |=> (bank_state_q[b] == BK_ACTIVE);
    endproperty
    a_row_stays: assert property (p_row_stays) else $error("open row closed without command");  // R16

    // Auto precharge read access period ends in precharging then idle
    property p_auto_pre;
      @(posedge link_clk_i) disable iff (lrst_q)
      (bank_state_q[b] == BK_RD_AUTO && bank_tmr_q[b] == 4'h0) |=> (bank_state_q[b] == BK_PRECHARGING)
        ##(PRECHARGE_CYC - 4'h1) (bank_state_q[b] == BK_IDLE);
    endproperty
    a_auto_pre: assert property (p_auto_pre) else $error("auto precharge sequence wrong");  // R6

    // Terminate aimed elsewhere leaves a reading bank alone
    property p_bst_own_bank;
      @(posedge link_clk_i) disable iff (lrst_q)
      (bst_go && last_rd_bank_q != BA_W'(b) && bank_state_q[b] == BK_READ && bank_tmr_q[b] > 4'h1
       && !is_pre) |=> (bank_state_q[b] == BK_READ && bank_tmr_q[b] == $past(bank_tmr_q[b]) - 4'h1);
    endproperty
    a_bst_own_bank: assert property (p_bst_own_bank) else $error("terminate touched another bank");  // R9
  end

  // Latency pipeline of reads and truncation tokens
  always_ff @(posedge link_clk_i)
  begin
    for (int i = 0; i < PIPE_D - 1; i++)
    begin
      if (push && i == int'(cl_cyc) - 1)
      begin
        rp_v_q[i]    <= ~lrst_q;
        rp_stop_q[i] <= ~rd_go;  // R22 R23
        rp_bank_q[i] <= ba_i;
        rp_col_q[i]  <= addr_i[COL_W-1:0];
      end
      else
      begin
        rp_v_q[i]    <= rp_v_q[i+1] & ~lrst_q;
        rp_stop_q[i] <= rp_stop_q[i+1];
        rp_bank_q[i] <= rp_bank_q[i+1];
        rp_col_q[i]  <= rp_col_q[i+1];
      end
    end
    rp_v_q[PIPE_D-1]    <= push & (cl_cyc == 2'h3) & ~lrst_q;
    rp_stop_q[PIPE_D-1] <= ~rd_go;
    rp_bank_q[PIPE_D-1] <= ba_i;
    rp_col_q[PIPE_D-1]  <= addr_i[COL_W-1:0];
  end

  assign brst_start = rp_v_q[0] & ~rp_stop_q[0];
  assign brst_last  = brst_start ? (pairs == 4'h1) : (~rp_v_q[0] & (brst_cnt_q == 4'h1));

  // Read data and strobe drive
  always_ff @(posedge link_clk_i)
  begin
    if (lrst_q)
    begin
      brst_cnt_q  <= 4'h0;
      brst_col_q  <= '0;
      brst_bank_q <= '0;
      brst_row_q  <= '0;
      dq_rise_o   <= '0;
      dq_fall_o   <= '0;
      dq_oe_o     <= 1'b0;
      dqs_o       <= 1'b0;
      dqs_oe_o    <= 1'b0;
      done_tgl_q  <= 1'b0;
    end
    else
    begin
      if (brst_last)
        done_tgl_q <= ~done_tgl_q;
      if (brst_start)
      begin
        // New burst, possibly cutting the running one
        brst_cnt_q  <= pairs - 4'h1;  // R20
        brst_col_q  <= rp_col_q[0] + COL_W'(2);
        brst_bank_q <= rp_bank_q[0];
        brst_row_q  <= bank_row_q[rp_bank_q[0]];
        dq_rise_o   <= elem(rp_bank_q[0], bank_row_q[rp_bank_q[0]], rp_col_q[0]);  // R17
        dq_fall_o   <= elem(rp_bank_q[0], bank_row_q[rp_bank_q[0]], rp_col_q[0] + COL_W'(1));
        dq_oe_o     <= 1'b1;
        dqs_o       <= 1'b1;  // R18
        dqs_oe_o    <= 1'b1;
      end
      else if (rp_v_q[0])
      begin
        // Truncation token: release the pins
        brst_cnt_q <= 4'h0;  // R22 R23
        dq_oe_o    <= 1'b0;
        dqs_o      <= 1'b0;
        dqs_oe_o   <= 1'b0;
      end
      else if (brst_cnt_q != 4'h0)
      begin
        brst_cnt_q <= brst_cnt_q - 4'h1;
        brst_col_q <= brst_col_q + COL_W'(2);
        dq_rise_o  <= elem(brst_bank_q, brst_row_q, brst_col_q);
        dq_fall_o  <= elem(brst_bank_q, brst_row_q, brst_col_q + COL_W'(1));
        dq_oe_o    <= 1'b1;
        dqs_o      <= 1'b1;
        dqs_oe_o   <= 1'b1;
      end
      else
      begin
        // Preamble one cycle ahead of data, else high impedance
        dq_oe_o  <= 1'b0;  // R19
        dqs_o    <= 1'b0;
        dqs_oe_o <= rp_v_q[1] & ~rp_stop_q[1];  // R18
      end
    end
  end

  // Read latency, preamble then data
  property p_read_latency;
    @(posedge link_clk_i) disable iff (lrst_q)
    (rd_go && cl_cyc == 2'h2 && !dq_oe_o && !dqs_oe_o && !rp_v_q[0] && !rp_v_q[1])
      |-> ##2 (dqs_oe_o && !dqs_o && !dq_oe_o) ##1 (dq_oe_o && dqs_o);
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read preamble or data late");  // R18

  // Pins released after the last pair
  property p_release;
    @(posedge link_clk_i) disable iff (lrst_q)
    (dq_oe_o && brst_cnt_q == 4'h0 && !rp_v_q[0]) |=> !dq_oe_o;
  endproperty
  a_release: assert property (p_release) else $error("data pins held after burst");  // R19

  // Terminate cuts data after the column latency
  property p_bst_latency;
    @(posedge link_clk_i) disable iff (lrst_q)
    (bst_go && cl_cyc == 2'h3 && !rd_go) ##1 (!rd_go) [*2] |-> ##2 !dq_oe_o;
  endproperty
  a_bst_latency: assert property (p_bst_latency) else $error("terminate latency wrong");  // R22

  // Deselect leaves idle banks idle
  property p_deselect;
    @(posedge link_clk_i) disable iff (lrst_q)
    (cs_n_i && all_idle_q && &bank_idle) |=> (&bank_idle && $stable(mode_q));
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect changed state");  // R2

  // Precharge all closes open banks 2 and 3
  property p_pre_all;
    @(posedge link_clk_i) disable iff (lrst_q)
    (is_pre && pre_all && bank_open[2] && bank_open[3])
      |=> (bank_state_q[2] == BK_PRECHARGING && bank_state_q[3] == BK_PRECHARGING);
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all missed a bank");  // R25

  // Level and event crossings into the reference clock domain
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      idle_sync_q <= 3'h0;
      busy_sync_q <= 3'h0;
      done_sync_q <= 3'h0;
    end
    else
    begin
      idle_sync_q <= {idle_sync_q[1:0], all_idle_q};
      busy_sync_q <= {busy_sync_q[1:0], dq_oe_o};
      done_sync_q <= {done_sync_q[1:0], done_tgl_q};
    end
  end

  assign all_banks_idle_o = idle_sync_q[1];
  assign read_busy_o      = busy_sync_q[1];
  assign read_done_o      = done_sync_q[2] ^ done_sync_q[1];

endmodule

// [include/sbr_pkg.sv]
// Constants, command codes and bank states for the DRAM bank command and read block.
// Assumes the link clock period below matches the command clock of the memory controller.
package sbr_pkg;

  // Geometry of the command and data pins
  localparam int BANKS  = 4;
  localparam int BA_W   = 2;
  localparam int ADDR_W = 13;
  localparam int COL_W  = 9;
  localparam int DQ_W   = 16;
  localparam int PIPE_D = 3;                 // Deepest column latency
  localparam int AUTO_PRECHARGE_SELECT_BIT = 10;

  // Link clock and minimum times, in ns
  localparam int LINK_PERIOD_NS               = 30;
  localparam int PRECHARGE_PERIOD_MIN_NS      = 60;
  localparam int ACTIVATE_TO_ACCESS_MIN_NS    = 60;
  localparam int WRITE_RECOVERY_MIN_NS        = 30;
  localparam int MODE_LOAD_DELAY_MIN_NS       = 60;

  // Minimum times rounded up to whole link cycles
  localparam logic [3:0] PRECHARGE_CYC = 4'((PRECHARGE_PERIOD_MIN_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [3:0] ACTIVATE_CYC  = 4'((ACTIVATE_TO_ACCESS_MIN_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [3:0] WR_RECOV_CYC  = 4'((WRITE_RECOVERY_MIN_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [3:0] MODE_LOAD_CYC = 4'((MODE_LOAD_DELAY_MIN_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);

  // Command codes on {row strobe, column strobe, write enable}, active low
  localparam logic [2:0] CMD_MODE  = 3'h0;
  localparam logic [2:0] CMD_ACT   = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ  = 3'h5;
  localparam logic [2:0] CMD_PRE   = 3'h2;
  localparam logic [2:0] CMD_BST   = 3'h6;

  // Mode word fields and reset value (burst of 4, column latency 3)
  localparam int         MODE_W      = 7;
  localparam int         MODE_BL_LSB = 0;
  localparam int         MODE_CL_LSB = 4;
  localparam logic [6:0] MODE_RESET  = 7'h32;
  localparam logic [2:0] BL_CODE_2   = 3'h1;
  localparam logic [2:0] BL_CODE_4   = 3'h2;
  localparam logic [2:0] BL_CODE_8   = 3'h3;
  localparam logic [2:0] CL_CODE_2   = 3'h2;

  // Per-bank state, one-hot
  typedef enum logic [7:0] {
    BK_IDLE        = 8'h01,
    BK_ACTIVATING  = 8'h02,
    BK_ACTIVE      = 8'h04,
    BK_READ        = 8'h08,
    BK_WRITE       = 8'h10,
    BK_RD_AUTO     = 8'h20,
    BK_WR_AUTO     = 8'h40,
    BK_PRECHARGING = 8'h80
  } sbr_bank_state_t;

endpackage

// [tb/sbr_ctrl_model.sv]
// Behavioural memory controller that issues DRAM commands on the link clock.
// Assumes the caller enters cmd just after a link clock rising edge.
`timescale 1ns/10ps
module sbr_ctrl_model
  import sbr_pkg::*;
(
  input  wire logic         link_clk_i,
  output logic              cke_o,
  output logic              cs_n_o,
  output logic              ras_n_o,
  output logic              cas_n_o,
  output logic              we_n_o,
  output logic [BA_W-1:0]   ba_o,
  output logic [ADDR_W-1:0] addr_o
);
  // Clock enable held high throughout, no power-down exits to wait for
  initial
  begin
    cke_o = 1'b1;
    cs_n_o = 1'b1;
    {ras_n_o, cas_n_o, we_n_o} = 3'h7;
    ba_o = '0;
    addr_o = '0;
  end

  // One command for one edge, then NOP with scrambled buses so stale values never pass
  // Callers space commands by bank timing; t_auto also sends reads to closed banks
  // Clear rel when another command follows at once, so no pin is driven twice in a step
  task automatic cmd(input logic [2:0] code, input logic [BA_W-1:0] ba, input logic [ADDR_W-1:0] addr,
                     input logic sel = 1'b1, input logic rel = 1'b1);
    cs_n_o = ~sel;
    {ras_n_o, cas_n_o, we_n_o} = code;
    ba_o = ba;
    addr_o = addr;
    @(posedge link_clk_i);
    #2;
    if (rel)
    begin
      cs_n_o = 1'b0;
      {ras_n_o, cas_n_o, we_n_o} = 3'h7;
      ba_o = ~ba;
      addr_o = ~addr;
    end
  endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for the bank command and read block.
// Assumes a controller model on the command pins and the pair data pattern of the design.
`timescale 1ns/10ps
module tb
  import sbr_pkg::*;
;
  logic              ref_clk_i = 1'b0;
  logic              link_clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              cke, cs_n, ras_n, cas_n, we_n;
  logic [BA_W-1:0]   ba;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0]   dq_rise_o, dq_fall_o;
  logic              dq_oe_o, dqs_o, dqs_oe_o, all_banks_idle_o, read_busy_o, read_done_o;
  int                n_errors = 0;
  int                compares = 0;
  int                cyc = 0;
  int                done_cnt = 0;
  logic              busy_seen = 1'b0;

  // Clocks: link clock unrelated in phase
  always #50 ref_clk_i = ~ref_clk_i;
  initial
  begin
    #7;
    forever #15 link_clk_i = ~link_clk_i;
  end

  sbr_ctrl_model i_sbr_ctrl_model (
    .link_clk_i (link_clk_i),
    .cke_o      (cke),
    .cs_n_o     (cs_n),
    .ras_n_o    (ras_n),
    .cas_n_o    (cas_n),
    .we_n_o     (we_n),
    .ba_o       (ba),
    .addr_o     (addr)
  );

  sbr_bank_read i_sbr_bank_read (
    .ref_clk_i        (ref_clk_i),
    .rst_i            (rst_i),
    .link_clk_i       (link_clk_i),
    .cke_i            (cke),
    .cs_n_i           (cs_n),
    .ras_n_i          (ras_n),
    .cas_n_i          (cas_n),
    .we_n_i           (we_n),
    .ba_i             (ba),
    .addr_i           (addr),
    .dq_rise_o        (dq_rise_o),
    .dq_fall_o        (dq_fall_o),
    .dq_oe_o          (dq_oe_o),
    .dqs_o            (dqs_o),
    .dqs_oe_o         (dqs_oe_o),
    .all_banks_idle_o (all_banks_idle_o),
    .read_busy_o      (read_busy_o),
    .read_done_o      (read_done_o)
  );

  // Completed-burst pulse count, busy seen and hang guard, sampled mid-cycle
  always @(negedge ref_clk_i)
  begin
    cyc++;
    if (read_done_o === 1'b1) done_cnt++;
    if (read_busy_o === 1'b1) busy_seen = 1'b1;
    if (cyc == 20000)
    begin
      n_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [DQ_W-1:0] seen, input logic [DQ_W-1:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic lk(input int n);
    repeat (n)
    begin
      @(posedge link_clk_i);
      #2;
    end
  endtask

  task automatic rf(input int n);
    repeat (n) @(posedge ref_clk_i);
    lk(1);
  endtask

  function automatic logic [DQ_W-1:0] elem(input logic [1:0] b, input logic [5:0] r, input logic [7:0] c);
    return {b, r, c};
  endfunction

  // Pairs on consecutive link cycles, first element with strobe rise
  task automatic pairs_chk(input logic [1:0] b, input logic [5:0] r, input logic [7:0] c, input int n);
    for (int p = 0; p < n; p++)
    begin
      lk(1);
      chk(dq_oe_o, 1'b1);
      chk(dqs_o, 1'b1);
      chk(dq_rise_o, elem(b, r, c + 8'(2 * p)));
      chk(dq_fall_o, elem(b, r, c + 8'(2 * p + 1)));
    end
  endtask

  // Preamble after w cycles, n pairs, then pins released
  task automatic rd_chk(input logic [1:0] b, input logic [5:0] r, input logic [7:0] c, input int n, input int w);
    lk(w);
    chk(dqs_oe_o, 1'b1);
    chk(dqs_o, 1'b0);
    chk(dq_oe_o, 1'b0);
    pairs_chk(b, r, c, n);
    lk(1);
    chk(dq_oe_o, 1'b0);
    chk(dqs_oe_o, 1'b0);
  endtask

  // Open a row, full burst at latency 3, then a deselected read that must do nothing
  task automatic t_basic();
    i_sbr_ctrl_model.cmd(CMD_ACT, 2'h1, 13'h0005);
    lk(1);
    i_sbr_ctrl_model.cmd(CMD_READ, 2'h1, 13'h0008);
    rd_chk(2'h1, 6'h05, 8'h08, 2, 2);
    i_sbr_ctrl_model.cmd(CMD_READ, 2'h1, 13'h0008, 1'b0);
    lk(4);
    chk(dqs_oe_o, 1'b0);
    rf(6);
    chk(16'(done_cnt), 16'h0001);
    chk(all_banks_idle_o, 1'b0);
    chk(read_busy_o, 1'b0);
  endtask

  // Terminate one cycle after the read keeps a single pair
  task automatic t_term();
    i_sbr_ctrl_model.cmd(CMD_READ, 2'h1, 13'h0020, 1'b1, 1'b0);
    i_sbr_ctrl_model.cmd(CMD_BST, 2'h1, 13'h0000);
    rd_chk(2'h1, 6'h05, 8'h20, 1, 1);
  endtask

  // Back-to-back reads: first cut after one pair, second follows seamlessly
  task automatic t_r2r();
    i_sbr_ctrl_model.cmd(CMD_READ, 2'h1, 13'h0040, 1'b1, 1'b0);
    i_sbr_ctrl_model.cmd(CMD_READ, 2'h1, 13'h0060);
    lk(1);
    chk(dqs_oe_o, 1'b1);
    pairs_chk(2'h1, 6'h05, 8'h40, 1);
    pairs_chk(2'h1, 6'h05, 8'h60, 2);
    lk(1);
    chk(dq_oe_o, 1'b0);
  endtask

  // Auto precharge closes the row; precharge all closes every open bank
  task automatic t_auto();
    i_sbr_ctrl_model.cmd(CMD_READ, 2'h1, 13'h0480);
    rd_chk(2'h1, 6'h05, 8'h80, 2, 2);
    i_sbr_ctrl_model.cmd(CMD_READ, 2'h1, 13'h0000);
    lk(4);
    chk(dqs_oe_o, 1'b0);
    rf(4);
    chk(all_banks_idle_o, 1'b1);
    i_sbr_ctrl_model.cmd(CMD_ACT, 2'h2, 13'h0007);
    lk(1);
    i_sbr_ctrl_model.cmd(CMD_ACT, 2'h3, 13'h0009);
    lk(2);
    // Reads to two banks, terminate names bank 2 but cuts the latest read only
    i_sbr_ctrl_model.cmd(CMD_READ, 2'h2, 13'h0000, 1'b1, 1'b0);
    i_sbr_ctrl_model.cmd(CMD_READ, 2'h3, 13'h0000, 1'b1, 1'b0);
    i_sbr_ctrl_model.cmd(CMD_BST, 2'h2, 13'h0000);
    pairs_chk(2'h2, 6'h07, 8'h00, 1);
    pairs_chk(2'h3, 6'h09, 8'h00, 1);
    lk(1);
    chk(dq_oe_o, 1'b0);
    i_sbr_ctrl_model.cmd(CMD_PRE, 2'h0, 13'h0400);
    lk(3);
    i_sbr_ctrl_model.cmd(CMD_READ, 2'h3, 13'h0000);
    lk(4);
    chk(dqs_oe_o, 1'b0);
    rf(4);
    chk(all_banks_idle_o, 1'b1);
  endtask

  // Mode load to latency 2, burst 8; then a read cut by precharge after one pair
  task automatic t_mode();
    i_sbr_ctrl_model.cmd(CMD_MODE, 2'h0, 13'h0023);
    lk(3);
    i_sbr_ctrl_model.cmd(CMD_ACT, 2'h0, 13'h0003);
    lk(1);
    i_sbr_ctrl_model.cmd(CMD_READ, 2'h0, 13'h0000);
    rd_chk(2'h0, 6'h03, 8'h00, 4, 1);
    i_sbr_ctrl_model.cmd(CMD_READ, 2'h0, 13'h0010, 1'b1, 1'b0);
    i_sbr_ctrl_model.cmd(CMD_PRE, 2'h0, 13'h0000);
    pairs_chk(2'h0, 6'h03, 8'h10, 1);
    lk(1);
    chk(dq_oe_o, 1'b0);
    rf(3);
    chk(busy_seen, 1'b1);
  endtask

  // Main sequence
  initial
  begin
    repeat (12) @(posedge ref_clk_i);
    #2;
    rst_i = 1'b0;
    lk(10);
    t_basic();
    t_term();
    t_r2r();
    t_auto();
    t_mode();
    lk(4);
    end_sim();
  end
endmodule
